/* File: pkg/imt_pkg.sv */
// Purpose: Shared constants and types for the I2C master transfer engine
// Assumes: 16-bit register port, byte addresses as printed
// Notes:   Field positions are given as bit indices of the 16-bit words
package imt_pkg;

    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [15:0] IMT_ADDR_ENABLE = 16'h4340;
    localparam logic [15:0] IMT_ADDR_CTRL = 16'h4342;
    localparam logic [15:0] IMT_ADDR_DATA = 16'h4344;

    // Control/status word bit positions
    localparam int IMT_CTL_START = 0;
    localparam int IMT_CTL_STOP = 1;
    localparam int IMT_CTL_SBUSY = 8;
    localparam int IMT_CTL_FBUSY = 9;

    // Data word bit positions
    localparam int IMT_DAT_ACK = 8;
    localparam int IMT_DAT_SEXEC = 9;
    localparam int IMT_DAT_FEXEC = 10;
    localparam int IMT_DAT_FRDY = 11;

    // Enable word bit position
    localparam int IMT_EN_ON = 0;

    // -------------------------------------------------------------------
    // Bit counts within one byte frame (nine clocks, index 0..8)
    // -------------------------------------------------------------------
    localparam logic [3:0] IMT_BIT_ACK = 4'h8;
    localparam logic [3:0] IMT_BIT_D6 = 4'h1;
    localparam logic [3:0] IMT_BIT_D0 = 4'h7;
    localparam logic [3:0] IMT_BIT_ONE = 4'h1;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        IMT_IDLE,
        IMT_START,
        IMT_HOLD,
        IMT_XFER,
        IMT_STOP1,
        IMT_STOP2
    } imt_st_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } imt_bus_req_t;

    typedef struct packed {
        logic fetch_ready;
        logic fetch_execute;
        logic send_execute;
        logic ack_bit;
        logic [7:0] byte_buffer;
    } imt_dat_t;

    typedef struct packed {
        imt_st_t st;
        logic half;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rx;
        logic tmr_prev;
        logic module_on;
        logic start_request;
        logic stop_request;
        logic send_busy;
        logic fetch_busy;
        imt_dat_t dat;
        logic [15:0] rdata;
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
        logic tbe_pulse;
        logic rbf_pulse;
    } imt_state_t;

endpackage

/* File: design/imt_sync.sv */
// Purpose: Two-stage synchroniser for inputs from outside sys_clk
// Assumes: Inputs are levels, slow against sys_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module imt_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } imt_sync_st_t;

    imt_sync_st_t r, n;

    always_comb begin
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;
endmodule

/* File: design/imt_core.sv */
// Purpose: Single-master I2C transfer engine with a 16-bit register port
// Assumes: tmr_clk is a free-running bit-rate clock from a timer
// Notes:   One SCL half period per rising tmr_clk edge; open-drain pins
//
// How it works
// - Enable bit readies engine and releases SCL
// - START pulls SDA low, SCL high
// - Start bit self-clears after START
// - Address byte carries direction in bit zero
// - Send waits for START or byte in flight
// - Load clears send bit, pulses buffer empty
// - Data out MSB first, changes at falling
// - Nine clocks; SDA released for ACK
// - Ack bit records slave ACK or NACK
// - Send busy during byte, clear when waiting
// - Send beats fetch when both set
// - Fetch releases SDA, samples as SCL falls
// - Fetch bit clears while sampling D6
// - Received byte loaded, ready set, cleared by read
// - Unread byte overwritten without protection
// - Fetch busy during byte, clear when waiting
// - Ninth clock drives software ack bit
// - Stop request after START yields STOP, then self-clears; idle, just clears
// - No pending request holds SCL low
// - No stretching, no repeated START
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module imt_core
    import imt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire imt_bus_req_t bus,
    output logic [15:0] rdata,
    input wire logic tmr_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic tbe_pulse,
    output logic rbf_pulse
);
    imt_state_t r, n;
    logic [2:0] pin_s;
    logic tick;
    logic scl_s;
    logic sda_s;

    // -------------------------------------------------------------------
    // Input sampling and bit-rate tick
    // -------------------------------------------------------------------
    imt_sync #(.W(3)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({tmr_clk, scl_in, sda_in}),
        .q(pin_s)
    );

    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];
    // Edge found on the synchronised copy only
    assign tick = pin_s[2] & ~r.tmr_prev;

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        n = r;
        n.tmr_prev = pin_s[2];
        n.tbe_pulse = 1'b0;
        n.rbf_pulse = 1'b0;
        n.rdata = 16'h0000;
        // Pins only ever pulled low; high comes from the pull-up
        n.scl_o = 1'b0;
        n.sda_o = 1'b0;

        // Reads first, so a byte landing this cycle keeps its ready flag
        if (bus.rd) begin
            unique case (bus.addr)
                IMT_ADDR_ENABLE: begin
                    n.rdata[IMT_EN_ON] = r.module_on;
                end
                IMT_ADDR_CTRL: begin
                    n.rdata[IMT_CTL_START] = r.start_request;
                    n.rdata[IMT_CTL_STOP] = r.stop_request;
                    n.rdata[IMT_CTL_SBUSY] = r.send_busy;
                    n.rdata[IMT_CTL_FBUSY] = r.fetch_busy;
                end
                IMT_ADDR_DATA: begin
                    n.rdata[7:0] = r.dat.byte_buffer;
                    n.rdata[IMT_DAT_ACK] = r.dat.ack_bit;
                    n.rdata[IMT_DAT_SEXEC] = r.dat.send_execute;
                    n.rdata[IMT_DAT_FEXEC] = r.dat.fetch_execute;
                    n.rdata[IMT_DAT_FRDY] = r.dat.fetch_ready;
                    n.dat.fetch_ready = 1'b0;
                end
                default: begin
                    n.rdata = 16'h0000;
                end
            endcase
        end

        // ---------------------------------------------------------------
        // Transfer sequencer
        // ---------------------------------------------------------------
        if (!r.module_on) begin
            // Dropping enable mid-byte leaves the bus undefined
            n.st = IMT_IDLE;
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.send_busy = 1'b0;
            n.fetch_busy = 1'b0;
        end else if (tick) begin
            unique case (r.st)
                IMT_IDLE: begin
                    n.scl_oe = 1'b0;
                    n.sda_oe = 1'b0;
                    if (r.stop_request) begin
                        n.stop_request = 1'b0;
                    end else if (r.start_request && scl_s && sda_s) begin
                        n.sda_oe = 1'b1;
                        n.st = IMT_START;
                    end
                end
                IMT_START: begin
                    n.scl_oe = 1'b1;
                    n.start_request = 1'b0;
                    n.st = IMT_HOLD;
                end
                IMT_HOLD: begin
                    // A pending start is not honoured until after STOP
                    if (r.dat.send_execute) begin
                        n.shift = r.dat.byte_buffer;
                        n.dat.send_execute = 1'b0;
                        n.tbe_pulse = 1'b1;
                        n.send_busy = 1'b1;
                        n.rx = 1'b0;
                        n.cnt = 4'h0;
                        n.half = 1'b0;
                        n.sda_oe = ~r.dat.byte_buffer[7];
                        n.st = IMT_XFER;
                    end else if (r.dat.fetch_execute) begin
                        n.fetch_busy = 1'b1;
                        n.rx = 1'b1;
                        n.cnt = 4'h0;
                        n.half = 1'b0;
                        n.sda_oe = 1'b0;
                        n.st = IMT_XFER;
                    end else if (r.stop_request) begin
                        n.sda_oe = 1'b1;
                        n.st = IMT_STOP1;
                    end
                    // Otherwise SCL stays low: wait state
                end
                IMT_XFER: begin
                    if (!r.half) begin
                        n.scl_oe = 1'b0;
                        n.half = 1'b1;
                    end else begin
                        n.scl_oe = 1'b1;
                        n.half = 1'b0;
                        n.cnt = 4'(r.cnt + IMT_BIT_ONE);
                        if (r.cnt == IMT_BIT_ACK) begin
                            if (!r.rx) begin
                                n.dat.ack_bit = sda_s;
                            end
                            n.send_busy = 1'b0;
                            n.fetch_busy = 1'b0;
                            n.sda_oe = 1'b0;
                            n.st = IMT_HOLD;
                        end else if (r.rx) begin
                            n.shift = {r.shift[6:0], sda_s};
                            if (r.cnt == IMT_BIT_D6) begin
                                n.dat.fetch_execute = 1'b0;
                            end
                            if (r.cnt == IMT_BIT_D0) begin
                                // No guard against an unread byte
                                n.dat.byte_buffer = {r.shift[6:0], sda_s};
                                n.dat.fetch_ready = 1'b1;
                                n.rbf_pulse = 1'b1;
                                n.sda_oe = ~r.dat.ack_bit;
                            end
                        end else begin
                            n.shift = {r.shift[6:0], 1'b0};
                            if (r.cnt == IMT_BIT_D0) begin
                                n.sda_oe = 1'b0;
                            end else begin
                                n.sda_oe = ~r.shift[6];
                            end
                        end
                    end
                end
                IMT_STOP1: begin
                    n.scl_oe = 1'b0;
                    n.st = IMT_STOP2;
                end
                IMT_STOP2: begin
                    n.sda_oe = 1'b0;
                    n.stop_request = 1'b0;
                    n.st = IMT_IDLE;
                end
            endcase
        end

        // Software writes last: a set from software beats a hardware clear
        if (bus.wr) begin
            unique case (bus.addr)
                IMT_ADDR_ENABLE: begin
                    n.module_on = bus.wdata[IMT_EN_ON];
                end
                IMT_ADDR_CTRL: begin
                    n.start_request = bus.wdata[IMT_CTL_START];
                    n.stop_request = bus.wdata[IMT_CTL_STOP];
                end
                IMT_ADDR_DATA: begin
                    n.dat.byte_buffer = bus.wdata[7:0];
                    n.dat.ack_bit = bus.wdata[IMT_DAT_ACK];
                    n.dat.send_execute = bus.wdata[IMT_DAT_SEXEC];
                    n.dat.fetch_execute = bus.wdata[IMT_DAT_FEXEC];
                end
                default: begin
                    n.module_on = r.module_on;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign rdata = r.rdata;
    assign scl_o = r.scl_o;
    assign scl_oe = r.scl_oe;
    assign sda_o = r.sda_o;
    assign sda_oe = r.sda_oe;
    assign tbe_pulse = r.tbe_pulse;
    assign rbf_pulse = r.rbf_pulse;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    en_release_a: assert property (
        !r.module_on |=> r.st == IMT_IDLE && !r.scl_oe && !r.sda_oe)
        else $error("lines not released while disabled");

    start_cond_a: assert property (
        r.st == IMT_START |-> r.sda_oe && !r.scl_oe)
        else $error("START not SDA low with SCL high");

    start_clr_a: assert property (
        r.module_on && r.st == IMT_START && tick && !bus.wr
        |=> !r.start_request && r.st == IMT_HOLD)
        else $error("start bit not cleared after START");

    send_load_a: assert property (
        r.module_on && tick && r.st == IMT_HOLD && r.dat.send_execute && !bus.wr
        |=> r.tbe_pulse && !r.dat.send_execute && r.send_busy ##1 !r.tbe_pulse)
        else $error("send load did not clear bit or pulse once");

    msb_out_a: assert property (
        r.st == IMT_XFER && !r.rx && r.cnt < IMT_BIT_ACK |-> r.sda_oe == !r.shift[7])
        else $error("SDA does not show shift MSB");

    ack_rel_a: assert property (
        r.st == IMT_XFER && !r.rx && r.cnt == IMT_BIT_ACK |-> !r.sda_oe)
        else $error("SDA not released in ack clock");

    ack_store_a: assert property (
        r.module_on && tick && r.st == IMT_XFER && !r.rx && r.half
        && r.cnt == IMT_BIT_ACK && !bus.wr |=> r.dat.ack_bit == $past(sda_s))
        else $error("ack bit does not match sampled SDA");

    fetch_clr_a: assert property (
        r.module_on && tick && r.st == IMT_XFER && r.rx && r.half
        && r.cnt == IMT_BIT_D6 && !bus.wr |=> !r.dat.fetch_execute)
        else $error("fetch bit not cleared at D6");

    ready_rd_a: assert property (
        bus.rd && bus.addr == IMT_ADDR_DATA && !n.rbf_pulse |=> !r.dat.fetch_ready)
        else $error("ready flag not cleared by data read");

    rx_ack_a: assert property (
        r.st == IMT_XFER && r.rx && r.cnt == IMT_BIT_ACK |-> r.sda_oe == !r.dat.ack_bit
        || $changed(r.dat.ack_bit))
        else $error("response bit not driven from ack bit");

    wait_low_a: assert property (
        r.st == IMT_HOLD |-> r.scl_oe && !r.send_busy && !r.fetch_busy)
        else $error("wait state does not hold SCL low idle");

    stop_end_a: assert property (
        r.module_on && tick && r.st == IMT_STOP2 && !bus.wr
        |=> !r.sda_oe && !r.scl_oe && !r.stop_request)
        else $error("STOP did not release lines and clear bit");

    send_busy_a: assert property (
        r.st == IMT_XFER && !r.rx |-> r.send_busy && !r.fetch_busy)
        else $error("send busy wrong during a sent byte");

    fetch_busy_a: assert property (
        r.st == IMT_XFER && r.rx |-> r.fetch_busy && !r.send_busy)
        else $error("fetch busy wrong during a received byte");

    rx_release_a: assert property (
        r.st == IMT_XFER && r.rx && r.cnt < IMT_BIT_ACK |-> !r.sda_oe)
        else $error("SDA not released while receiving");

    nine_clk_a: assert property (
        r.st == IMT_XFER |-> r.cnt <= IMT_BIT_ACK)
        else $error("byte frame longer than nine clocks");

    stop_cond_a: assert property (
        r.st == IMT_STOP2 |-> r.sda_oe && !r.scl_oe)
        else $error("STOP not preceded by SDA low with SCL high");

    ready_set_a: assert property (
        r.rbf_pulse |-> r.dat.fetch_ready)
        else $error("ready flag not set with received byte");

    tx_byte_c: cover property (r.tbe_pulse ##[1:1000] r.st == IMT_HOLD);
    rx_byte_c: cover property (r.rbf_pulse);
    rx_nack_c: cover property (r.st == IMT_XFER && r.rx && r.cnt == IMT_BIT_ACK
        && !r.sda_oe);
    stop_c: cover property (r.st == IMT_STOP2 ##1 r.st == IMT_IDLE);
    wait_c: cover property (r.st == IMT_HOLD && tick && !r.dat.send_execute
        && !r.dat.fetch_execute && !r.stop_request);
endmodule

/* File: test/imt_slave.sv */
// Purpose: Behavioural I2C slave standing on the far side of the engine
// Assumes: SCL and SDA are wired-AND lines with pull-ups, levels already resolved
// Notes:   Acks written bytes unless nack is high; sends tx_byte when addressed for read
`timescale 1ns/1ps
module imt_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    input wire logic [7:0] tx_byte,
    output logic pull,
    output logic [7:0] got,
    output logic mack,
    output int starts,
    output int stops
);
    logic act;
    logic first;
    logic rd_dir;
    logic [7:0] sh;
    int bitn;
    wire sda_dl;

    // SDA may move in the step in which SCL falls; conditions see it a little later
    assign #1 sda_dl = sda;

    initial begin
        pull = 1'b0;
        act = 1'b0;
        first = 1'b0;
        rd_dir = 1'b0;
        sh = 8'h00;
        bitn = 0;
        got = 8'h00;
        mack = 1'b1;
        starts = 0;
        stops = 0;
    end

    // -------------------------------------------------------------------
    // Bus conditions
    // -------------------------------------------------------------------
    always @(negedge sda_dl) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            first = 1'b1;
            rd_dir = 1'b0;
            bitn = 0;
            starts++;
        end
    end

    always @(posedge sda_dl) begin
        if (scl === 1'b1 && act) begin
            act = 1'b0;
            pull = 1'b0;
            stops++;
        end
    end

    // -------------------------------------------------------------------
    // Bit level: sample on rise, change on fall
    // -------------------------------------------------------------------
    always @(posedge scl) begin
        if (act) begin
            if (bitn < 8) begin
                sh = {sh[6:0], sda};
            end else begin
                mack = sda;
            end
            bitn++;
        end
    end

    // No stretching: SCL is never held by this model
    always @(negedge scl) begin
        if (act) begin
            if (bitn == 8) begin
                if (first || !rd_dir) begin
                    got = sh;
                    if (first) begin
                        rd_dir = sh[0];
                    end
                    pull = !nack;
                end else begin
                    pull = 1'b0;
                end
            end else if (bitn == 9) begin
                bitn = 0;
                first = 1'b0;
                // A master NACK ends the read, so the line is left free for STOP
                pull = rd_dir && !mack && !tx_byte[7];
            end else if (rd_dir && !first) begin
                pull = !tx_byte[7 - bitn];
            end
        end
    end
endmodule

/* File: test/i2c_master_transfer_control_test.sv */
// Purpose: Register-level tests of the I2C transfer engine against a slave model
// Assumes: Free-running 64 ns bit-rate clock, pull-ups on both lines
// Notes:   Status is polled over the register port with bounded loops
`timescale 1ns/1ps
module i2c_master_transfer_control_test;
    import imt_pkg::*;

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t: mismatch got %0h exp %0h", $time, (a), (b)); end end

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic tmr_clk = 1'b0;
    imt_bus_req_t bus = '0;
    logic [15:0] rdata;
    logic scl_o, scl_oe, sda_o, sda_oe, tbe_pulse, rbf_pulse;
    logic pull, mack;
    logic nack = 1'b0;
    logic [7:0] tx_byte = 8'h5a;
    logic [7:0] got;
    logic scl_w, sda_w;
    logic [15:0] d;
    int starts, stops;
    int miscompares = 0;
    int comparisons = 0;
    int tbe_n = 0;
    int rbf_n = 0;

    // Open-drain lines with pull-ups
    assign scl_w = !scl_oe;
    assign sda_w = !(sda_oe || pull);

    always #2.5 sys_clk = ~sys_clk;
    initial begin
        #3.3;
        forever #32 tmr_clk = ~tmr_clk;
    end

    always @(posedge sys_clk) begin
        if (tbe_pulse === 1'b1) tbe_n++;
        if (rbf_pulse === 1'b1) rbf_n++;
    end

    imt_core uut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .tmr_clk(tmr_clk),
        .scl_in(scl_w), .sda_in(sda_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
        .sda_oe(sda_oe), .tbe_pulse(tbe_pulse), .rbf_pulse(rbf_pulse));

    imt_slave slave (.scl(scl_w), .sda(sda_w), .nack(nack), .tx_byte(tx_byte), .pull(pull),
        .got(got), .mack(mack), .starts(starts), .stops(stops));

    // -------------------------------------------------------------------
    // Bus tasks
    // -------------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        v = rdata;
        @(posedge sys_clk);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Polls one status bit; a hang counts as a mismatch and ends the run
    task automatic wait_bit(input logic [15:0] a, input int b, input logic v);
        logic [15:0] x;
        for (int i = 0; i < 3000; i++) begin
            rd(a, x);
            if (x[b] === v) return;
        end
        miscompares++;
        $display("ERROR %0t: status wait timed out", $time);
        finish_test();
    endtask

    task automatic busy_cycle(input int b);
        wait_bit(IMT_ADDR_CTRL, b, 1'b1);
        wait_bit(IMT_ADDR_CTRL, b, 1'b0);
    endtask

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);

        rd(IMT_ADDR_ENABLE, d); `CHK(d, 16'h0000)
        rd(IMT_ADDR_CTRL, d); `CHK(d, 16'h0000)
        rd(IMT_ADDR_DATA, d); `CHK(d, 16'h0000)
        wr(16'h4346, 16'hffff);
        rd(16'h4346, d); `CHK(d, 16'h0000)
        wr(IMT_ADDR_ENABLE, 16'h0001);
        rd(IMT_ADDR_ENABLE, d); `CHK(d, 16'h0001)
        `CHK(scl_oe, 1'b0)
        `CHK(sda_oe, 1'b0)
        `CHK(scl_o, 1'b0)
        `CHK(sda_o, 1'b0)
        $display("Test enable done");

        // Write address 0x52, direction write, then START; send waits for START
        wr(IMT_ADDR_DATA, 16'h02a4);
        wr(IMT_ADDR_CTRL, 16'h0001);
        wait_bit(IMT_ADDR_CTRL, IMT_CTL_SBUSY, 1'b1);
        rd(IMT_ADDR_CTRL, d); `CHK(d[IMT_CTL_START], 1'b0)
        rd(IMT_ADDR_DATA, d); `CHK(d[IMT_DAT_SEXEC], 1'b0)
        `CHK(tbe_n, 1)
        `CHK(starts, 1)
        wait_bit(IMT_ADDR_CTRL, IMT_CTL_SBUSY, 1'b0);
        `CHK(got, 8'ha4)
        rd(IMT_ADDR_DATA, d); `CHK(d[IMT_DAT_ACK], 1'b0)
        repeat (40) @(posedge sys_clk);
        `CHK(scl_oe, 1'b1)
        rd(IMT_ADDR_CTRL, d); `CHK(d, 16'h0000)
        $display("Test address write done");

        nack <= 1'b1;
        wr(IMT_ADDR_DATA, 16'h023c);
        busy_cycle(IMT_CTL_SBUSY);
        `CHK(got, 8'h3c)
        rd(IMT_ADDR_DATA, d); `CHK(d[IMT_DAT_ACK], 1'b1)
        nack <= 1'b0;
        $display("Test nack byte done");

        wr(IMT_ADDR_CTRL, 16'h0002);
        wait_bit(IMT_ADDR_CTRL, IMT_CTL_STOP, 1'b0);
        `CHK(stops, 1)
        `CHK(scl_oe, 1'b0)
        `CHK(sda_oe, 1'b0)
        $display("Test stop done");

        // Ten-bit address: header byte with the two high bits, then the low byte
        wr(IMT_ADDR_DATA, 16'h02f4);
        wr(IMT_ADDR_CTRL, 16'h0001);
        busy_cycle(IMT_CTL_SBUSY);
        `CHK(got, 8'hf4)
        wr(IMT_ADDR_DATA, 16'h0234);
        busy_cycle(IMT_CTL_SBUSY);
        `CHK(got, 8'h34)
        rd(IMT_ADDR_DATA, d); `CHK(d[IMT_DAT_ACK], 1'b0)
        wr(IMT_ADDR_CTRL, 16'h0002);
        wait_bit(IMT_ADDR_CTRL, IMT_CTL_STOP, 1'b0);
        `CHK(stops, 2)
        $display("Test ten-bit address done");

        // Send and fetch set together: address goes out first, then one byte in
        wr(IMT_ADDR_DATA, 16'h06a5);
        wr(IMT_ADDR_CTRL, 16'h0001);
        busy_cycle(IMT_CTL_FBUSY);
        `CHK(got, 8'ha5)
        `CHK(starts, 3)
        `CHK(tbe_n, 5)
        rd(IMT_ADDR_DATA, d); `CHK(d, 16'h085a)
        `CHK(rbf_n, 1)
        `CHK(mack, 1'b0)
        rd(IMT_ADDR_DATA, d); `CHK(d, 16'h005a)
        $display("Test fetch done");

        // Two fetches without a read: the second byte replaces the first
        wr(IMT_ADDR_DATA, 16'h0400);
        busy_cycle(IMT_CTL_FBUSY);
        tx_byte <= 8'h3c;
        wr(IMT_ADDR_DATA, 16'h0500);
        busy_cycle(IMT_CTL_FBUSY);
        rd(IMT_ADDR_DATA, d); `CHK(d, 16'h093c)
        `CHK(rbf_n, 3)
        `CHK(mack, 1'b1)
        wr(IMT_ADDR_CTRL, 16'h0002);
        wait_bit(IMT_ADDR_CTRL, IMT_CTL_STOP, 1'b0);
        `CHK(stops, 3)
        $display("Test overwrite done");

        // Enable dropped only once the bus is free again
        wr(IMT_ADDR_ENABLE, 16'h0000);
        rd(IMT_ADDR_ENABLE, d); `CHK(d, 16'h0000)
        `CHK(scl_oe, 1'b0)
        $display("Test disable done");

        finish_test();
    end
endmodule
